//--- hdl/asbd_pkg.sv
/*
 * Constants, register map and state type for the serial baud/data register block.
 * Assumes a 32-bit APB host. Registers sit at index*4; the bus clock is the baud source.
 */
package asbd_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is index times four)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 12;
	localparam logic [9:0] IDX_STATUS = 10'h050;
	localparam logic [9:0] IDX_DATA = 10'h051;
	localparam logic [9:0] IDX_BRR = 10'h052;
	localparam logic [9:0] IDX_CR1 = 10'h053;
	localparam logic [9:0] IDX_CR2 = 10'h054;
	localparam logic [9:0] IDX_RX_EXT = 10'h055;
	localparam logic [9:0] IDX_TX_EXT = 10'h057;
	localparam logic [9:0] IDX_IRQ_STAT = 10'h058;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h059;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned ST_TX_EMPTY_FLAG = 7;
	localparam int unsigned ST_TC = 6;
	localparam int unsigned ST_RX_READY_FLAG = 5;
	localparam int unsigned ST_IDLE = 4;
	localparam int unsigned ST_OVR = 3;
	localparam int unsigned ST_NF = 2;
	localparam int unsigned ST_FE = 1;
	localparam int unsigned ST_PE = 0;
	localparam int unsigned BRR_PR_LSB = 6;
	localparam int unsigned BRR_TR_LSB = 3;
	localparam int unsigned BRR_RR_LSB = 0;
	localparam int unsigned CR1_SCID = 5;
	localparam int unsigned IRQ_RX = 0;
	localparam int unsigned IRQ_TXE = 1;
	localparam int unsigned IRQ_OVR = 2;
	localparam int unsigned IRQ_TC = 3;
	localparam int unsigned IRQ_W = 4;
	localparam int unsigned DIR_RX = 0;
	localparam int unsigned DIR_TX = 1;
	localparam int unsigned PRE_W = 11;

	// ----------------------------------------------------------------
	// Values
	// ----------------------------------------------------------------
	localparam logic [7:0] STATUS_RST = 8'hC0;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] CR1_WMASK = 8'h7F;
	localparam logic [5:0] RX_FLAGS = 6'h3F;
	localparam logic [3:0] PR_FACT_0 = 4'h1;
	localparam logic [3:0] PR_FACT_1 = 4'h3;
	localparam logic [3:0] PR_FACT_2 = 4'h4;
	localparam logic [3:0] PR_FACT_3 = 4'hD;
	localparam logic [3:0] CNT16_LAST = 4'hF;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] tx_holding_reg;
		logic [7:0] rx_holding_reg;
		logic [7:0] brr;
		logic [7:0] cr1;
		logic [7:0] cr2;
		logic [1:0][7:0] ext;
		logic seq_armed;
		logic [1:0][PRE_W-1:0] pre_cnt;
		logic [1:0][3:0] cnt16;
		logic [1:0][7:0] ext_cnt;
		logic [1:0] rate_tick;
		logic [1:0] bit_tick;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_mask;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} asbd_state_s;

	localparam asbd_state_s STATE_RST = '{status: STATUS_RST, default: '0};

endpackage : asbd_pkg

//--- hdl/asbd_serial_regs.sv
/*
 * Data holding registers, baud rate generator and status flags of an
 * asynchronous serial transceiver, reached over APB.
 * Assumes shift engines on the same clock: they take the transmit byte,
 * deliver received bytes and use the rate and bit ticks.
 */
// Chosen here: the APB register port.
// Notes on behaviour
// - One data address: writes fill transmit holding, reads return receive holding.
// - Transmit holding byte goes in parallel to the output shift register.
// - Receive holding takes each assembled byte in parallel for bus reads, unless the ready flag is still set (overrun keeps the held byte).
// - Coarse prescaler code 00,01,10,11 divides by 1, 3, 4, 13.
// - Transmit divisor code selects 1 to 128, doubling per step.
// - Conventional transmit rate clock is bus clock over prescaler times divisor.
// - Receive divisor uses same table, independent from transmit.
// - Non-zero extended prescaler selects extended generation; zero keeps conventional.
// - Extended mode divides the divide-by-16 output by the value, 1 to 255.
// - Receive extended prescaler affects only receive rate.
// - Transmit extended prescaler affects only transmit rate.
// - Both extended prescalers are zero after reset.
// - Receive flags clear only by status access (read or write) followed by data read.

`timescale 1ns/1ps
`default_nettype none

module asbd_serial_regs (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [asbd_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Transmit engine side
	output logic [7:0] o_tx_data,
	output logic o_tx_empty,
	input wire logic i_tx_taken,
	input wire logic i_tx_done,
	// Receive engine side
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_noise,
	input wire logic i_rx_frame_err,
	input wire logic i_rx_parity_err,
	input wire logic i_rx_idle,
	// Rate ticks
	output logic o_rx_rate_tick,
	output logic o_rx_bit_tick,
	output logic o_tx_rate_tick,
	output logic o_tx_bit_tick,
	// Control to engines and interrupt
	output logic [7:0] o_ctrl_one,
	output logic [7:0] o_ctrl_two,
	output logic o_irq
);

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] pr_factor(input logic [1:0] code);
		logic [3:0] f;
		unique case (code)
			2'b00: f = asbd_pkg::PR_FACT_0;
			2'b01: f = asbd_pkg::PR_FACT_1;
			2'b10: f = asbd_pkg::PR_FACT_2;
			default: f = asbd_pkg::PR_FACT_3;
		endcase
		return f;
	endfunction : pr_factor

	// Last count of the pre-divider: prescale factor times two to the code, minus one
	function automatic logic [asbd_pkg::PRE_W-1:0] div_limit(input logic [1:0] pr,
			input logic [2:0] div);
		logic [asbd_pkg::PRE_W-1:0] p;
		p = {7'h00, pr_factor(pr)} << div;
		return p - 11'h001;
	endfunction : div_limit

	function automatic logic is_mapped(input logic [asbd_pkg::ADDR_W-1:0] a);
		logic [9:0] idx;
		idx = a[11:2];
		return (a[1:0] == 2'b00) && (idx == asbd_pkg::IDX_STATUS || idx == asbd_pkg::IDX_DATA
			|| idx == asbd_pkg::IDX_BRR || idx == asbd_pkg::IDX_CR1
			|| idx == asbd_pkg::IDX_CR2 || idx == asbd_pkg::IDX_RX_EXT
			|| idx == asbd_pkg::IDX_TX_EXT || idx == asbd_pkg::IDX_IRQ_STAT
			|| idx == asbd_pkg::IDX_IRQ_MASK);
	endfunction : is_mapped

	function automatic logic [7:0] read_mux(input asbd_pkg::asbd_state_s s,
			input logic [9:0] idx);
		logic [7:0] v;
		v = 8'h00;
		if (idx == asbd_pkg::IDX_STATUS)
			v = s.status;
		else if (idx == asbd_pkg::IDX_DATA)
			v = s.rx_holding_reg;
		else if (idx == asbd_pkg::IDX_BRR)
			v = s.brr;
		else if (idx == asbd_pkg::IDX_CR1)
			v = s.cr1;
		else if (idx == asbd_pkg::IDX_CR2)
			v = s.cr2;
		else if (idx == asbd_pkg::IDX_RX_EXT)
			v = s.ext[asbd_pkg::DIR_RX];
		else if (idx == asbd_pkg::IDX_TX_EXT)
			v = s.ext[asbd_pkg::DIR_TX];
		else if (idx == asbd_pkg::IDX_IRQ_STAT)
			v = {4'h0, s.irq_st};
		else if (idx == asbd_pkg::IDX_IRQ_MASK)
			v = {4'h0, s.irq_mask};
		return v;
	endfunction : read_mux

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	asbd_pkg::asbd_state_s q;
	asbd_pkg::asbd_state_s d;
	logic [9:0] idx;
	logic mapped;
	logic setup;
	logic access;
	logic wr;
	logic rd;

	assign idx = i_paddr[11:2];
	assign mapped = is_mapped(i_paddr);
	assign setup = i_psel && !i_penable;
	assign access = i_psel && i_penable && q.pready;
	assign wr = access && i_pwrite && mapped;
	assign rd = access && !i_pwrite && mapped;

	always_comb
	begin
		logic [asbd_pkg::PRE_W-1:0] lim;
		logic [2:0] dcode;
		lim = '0;
		dcode = 3'h0;
		d = q;
		d.rate_tick = 2'b00;
		d.bit_tick = 2'b00;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		d.prdata = 32'h00000000;

		// ------------------------------------------------------------
		// APB answer: ready one cycle after setup, so no wait states
		// ------------------------------------------------------------
		if (setup)
		begin
			d.pready = 1'b1;
			d.pslverr = !mapped;
			if (!i_pwrite && mapped)
				d.prdata = {24'h000000, read_mux(q, idx)};
		end

		// ------------------------------------------------------------
		// Baud generation, one chain per direction
		// ------------------------------------------------------------
		for (int k = 0; k < 2; k++)
		begin
			dcode = (k == asbd_pkg::DIR_RX) ? q.brr[asbd_pkg::BRR_RR_LSB +: 3]
				: q.brr[asbd_pkg::BRR_TR_LSB +: 3];
			lim = div_limit(q.brr[asbd_pkg::BRR_PR_LSB +: 2], dcode);
			if (q.cr1[asbd_pkg::CR1_SCID])
			begin
				// Low power: prescaler counters cleared and held at zero
				d.pre_cnt[k] = '0;
				d.cnt16[k] = 4'h0;
				d.ext_cnt[k] = 8'h00;
			end
			// Greater-or-equal so a lowered divisor cannot strand the counter
			else if (q.pre_cnt[k] >= lim)
			begin
				d.pre_cnt[k] = '0;
				d.rate_tick[k] = 1'b1;
				d.cnt16[k] = q.cnt16[k] + 4'h1;
				if (q.cnt16[k] == asbd_pkg::CNT16_LAST)
				begin
					if (q.ext[k] == 8'h00)
						d.bit_tick[k] = 1'b1;
					else if (q.ext_cnt[k] >= q.ext[k] - 8'h01)
					begin
						d.ext_cnt[k] = 8'h00;
						d.bit_tick[k] = 1'b1;
					end
					else
						d.ext_cnt[k] = q.ext_cnt[k] + 8'h01;
				end
			end
			else
				d.pre_cnt[k] = q.pre_cnt[k] + 11'h001;
		end

		// ------------------------------------------------------------
		// Transmit holding register
		// ------------------------------------------------------------
		if (i_tx_taken && !q.status[asbd_pkg::ST_TX_EMPTY_FLAG])
			d.status[asbd_pkg::ST_TX_EMPTY_FLAG] = 1'b1;

		// ------------------------------------------------------------
		// Register writes and read side effects
		// ------------------------------------------------------------
		if (access && mapped && idx == asbd_pkg::IDX_STATUS)
			d.seq_armed = 1'b1;
		if (wr)
		begin
			if (idx == asbd_pkg::IDX_DATA)
			begin
				d.tx_holding_reg = i_pwdata[7:0];
				d.status[asbd_pkg::ST_TX_EMPTY_FLAG] = 1'b0;
				if (q.seq_armed)
					d.status[asbd_pkg::ST_TC] = 1'b0;
				d.seq_armed = 1'b0;
			end
			else if (idx == asbd_pkg::IDX_BRR)
				d.brr = i_pwdata[7:0];
			else if (idx == asbd_pkg::IDX_CR1)
				d.cr1 = (q.cr1 & ~asbd_pkg::CR1_WMASK) | (i_pwdata[7:0] & asbd_pkg::CR1_WMASK);
			else if (idx == asbd_pkg::IDX_CR2)
				d.cr2 = i_pwdata[7:0];
			else if (idx == asbd_pkg::IDX_RX_EXT)
				d.ext[asbd_pkg::DIR_RX] = i_pwdata[7:0];
			else if (idx == asbd_pkg::IDX_TX_EXT)
				d.ext[asbd_pkg::DIR_TX] = i_pwdata[7:0];
			else if (idx == asbd_pkg::IDX_IRQ_STAT)
				d.irq_st = q.irq_st & ~i_pwdata[asbd_pkg::IRQ_W-1:0];
			else if (idx == asbd_pkg::IDX_IRQ_MASK)
				d.irq_mask = i_pwdata[asbd_pkg::IRQ_W-1:0];
		end
		if (rd && idx == asbd_pkg::IDX_DATA)
		begin
			if (q.seq_armed)
				d.status[5:0] = q.status[5:0] & ~asbd_pkg::RX_FLAGS;
			d.seq_armed = 1'b0;
		end

		// ------------------------------------------------------------
		// Hardware sets come last so they win over a clear
		// ------------------------------------------------------------
		if (i_rx_valid)
		begin
			if (d.status[asbd_pkg::ST_RX_READY_FLAG])
			begin
				// Held byte kept; a frame error on this byte is not reported
				d.status[asbd_pkg::ST_OVR] = 1'b1;
				d.irq_st[asbd_pkg::IRQ_OVR] = 1'b1;
			end
			else
			begin
				d.rx_holding_reg = i_rx_data;
				d.status[asbd_pkg::ST_RX_READY_FLAG] = 1'b1;
				d.status[asbd_pkg::ST_NF] = d.status[asbd_pkg::ST_NF] | i_rx_noise;
				d.status[asbd_pkg::ST_FE] = d.status[asbd_pkg::ST_FE] | i_rx_frame_err;
				d.status[asbd_pkg::ST_PE] = d.status[asbd_pkg::ST_PE] | i_rx_parity_err;
				d.irq_st[asbd_pkg::IRQ_RX] = 1'b1;
			end
		end
		// Emptied event must beat a same-cycle write-one clear of its bit
		if (i_tx_taken && !q.status[asbd_pkg::ST_TX_EMPTY_FLAG])
			d.irq_st[asbd_pkg::IRQ_TXE] = 1'b1;
		if (i_rx_idle)
			d.status[asbd_pkg::ST_IDLE] = 1'b1;
		if (i_tx_done)
		begin
			d.status[asbd_pkg::ST_TC] = 1'b1;
			d.irq_st[asbd_pkg::IRQ_TC] = 1'b1;
		end
		d.irq = |(d.irq_st & d.irq_mask);
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			q <= asbd_pkg::STATE_RST;
		else
			q <= d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_prdata = q.prdata;
	assign o_pready = q.pready;
	assign o_pslverr = q.pslverr;
	assign o_tx_data = q.tx_holding_reg;
	assign o_tx_empty = q.status[asbd_pkg::ST_TX_EMPTY_FLAG];
	assign o_rx_rate_tick = q.rate_tick[asbd_pkg::DIR_RX];
	assign o_rx_bit_tick = q.bit_tick[asbd_pkg::DIR_RX];
	assign o_tx_rate_tick = q.rate_tick[asbd_pkg::DIR_TX];
	assign o_tx_bit_tick = q.bit_tick[asbd_pkg::DIR_TX];
	assign o_ctrl_one = q.cr1;
	assign o_ctrl_two = q.cr2;
	assign o_irq = q.irq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	sequence status_access_s;
		access && mapped && idx == asbd_pkg::IDX_STATUS;
	endsequence

	sequence data_read_s;
		rd && idx == asbd_pkg::IDX_DATA;
	endsequence

	sequence data_write_s;
		wr && idx == asbd_pkg::IDX_DATA;
	endsequence

	data_write_a: assert property (data_write_s |=> o_tx_data == $past(i_pwdata[7:0])
		&& !o_tx_empty)
		else $error("data write did not load transmit holding");

	data_read_a: assert property (setup && !i_pwrite && mapped && idx == asbd_pkg::IDX_DATA
		|=> o_prdata == {24'h000000, $past(q.rx_holding_reg)} && o_pready)
		else $error("data read did not return receive holding");

	rx_load_a: assert property (i_rx_valid && !q.status[asbd_pkg::ST_RX_READY_FLAG]
		&& !(rd && idx == asbd_pkg::IDX_DATA)
		|=> q.rx_holding_reg == $past(i_rx_data) && q.status[asbd_pkg::ST_RX_READY_FLAG])
		else $error("received byte not captured");

	tx_hand_a: assert property (i_tx_taken && !o_tx_empty && !(wr && idx == asbd_pkg::IDX_DATA)
		|=> o_tx_empty && o_tx_data == $past(o_tx_data))
		else $error("transmit hand-over failed");

	pr_table_a: assert property (o_tx_rate_tick && $past(q.brr[7:6]) == 2'b11
		&& $past(q.brr[5:3]) == 3'b000 |-> $past(q.pre_cnt[1]) >= 11'd12)
		else $error("prescale 13 tick too early");

	rx_table_a: assert property (o_rx_rate_tick && $past(q.brr[7:6]) == 2'b00
		&& $past(q.brr[2:0]) == 3'b111 |-> $past(q.pre_cnt[0]) >= 11'd127)
		else $error("receive divisor 128 tick too early");

	tx_rate_a: assert property (!q.cr1[asbd_pkg::CR1_SCID] && q.brr[7:3] == 5'b00001
		&& q.pre_cnt[1] == 11'd1 |=> o_tx_rate_tick)
		else $error("transmit divide by two missed its tick");

	conv_bit_a: assert property (o_tx_bit_tick |-> o_tx_rate_tick
		&& $past(q.cnt16[1]) == 4'hF)
		else $error("bit tick not on sixteenth rate tick");

	ext_mode_a: assert property (o_rx_bit_tick && $past(q.ext[0]) != 8'h00
		|-> $past(q.ext_cnt[0]) >= $past(q.ext[0]) - 8'h01 && q.ext_cnt[0] == 8'h00)
		else $error("extended receive division wrong");

	ext_reset_a: assert property ($fell(i_rst) |-> q.ext == 16'h0000)
		else $error("extended prescalers not zero after reset");

	flag_arm_a: assert property (status_access_s |=> q.seq_armed)
		else $error("status access did not arm clearing");

	flag_clear_a: assert property (q.seq_armed ##0 data_read_s ##0 (!i_rx_valid && !i_rx_idle)
		|=> q.status[5:0] == 6'h00)
		else $error("flags not cleared by status then data read");

	flag_keep_a: assert property ((!q.seq_armed && q.status[asbd_pkg::ST_RX_READY_FLAG]) and data_read_s
		|=> q.status[asbd_pkg::ST_RX_READY_FLAG])
		else $error("ready flag cleared without status access");

	scid_stop_a: assert property (q.cr1[asbd_pkg::CR1_SCID] |=> !o_tx_rate_tick && !o_rx_rate_tick)
		else $error("prescalers ran while disabled");

	irq_level_a: assert property (o_irq == |(q.irq_st & q.irq_mask))
		else $error("interrupt without unmasked status");

endmodule : asbd_serial_regs

`default_nettype wire

//--- test/asbd_engine_model.sv
/*
 * Behavioural model of the shift engines on the far side of the data and baud block.
 * Assumes the same clock as the block; the bench commands takes and received bytes.
 */
`timescale 1ns/1ps
`default_nettype none

module asbd_engine_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Bench control
	input wire logic i_take_en,
	input wire logic i_send,
	input wire logic [7:0] i_byte,
	output logic [7:0] o_last_tx,
	// Block side
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_empty,
	output logic o_tx_taken,
	output logic o_tx_done,
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	output logic o_rx_noise,
	output logic o_rx_frame_err,
	output logic o_rx_parity_err,
	output logic o_rx_idle
);
	logic [1:0] done_dly;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_tx_taken <= 1'b0;
			o_tx_done <= 1'b0;
			o_last_tx <= 8'h00;
			done_dly <= 2'h0;
			o_rx_valid <= 1'b0;
			o_rx_data <= 8'h00;
			o_rx_idle <= 1'b0;
		end
		else
		begin
			// One take per loaded byte; the take pulse itself blocks a second one
			o_tx_taken <= i_take_en && !i_tx_empty && !o_tx_taken;
			if (o_tx_taken)
				o_last_tx <= i_tx_data;
			done_dly <= {done_dly[0], o_tx_taken};
			o_tx_done <= done_dly[1];
			o_rx_valid <= i_send;
			// Off-frame the data lines toggle, so a stale byte is never mistaken for valid
			o_rx_data <= i_send ? i_byte : ~o_rx_data;
			o_rx_idle <= o_rx_valid;
		end
	end

	assign o_rx_noise = 1'b0;
	assign o_rx_frame_err = 1'b0;
	assign o_rx_parity_err = 1'b0;
endmodule : asbd_engine_model

`default_nettype wire

//--- test/async_serial_baud_and_data_regs_tb.sv
/*
 * Self-checking bench for the serial data and baud register block.
 * Assumes the engine model in its own file and the block's package.
 */
`timescale 1ns/1ps
`default_nettype none

module async_serial_baud_and_data_regs_tb;
	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] tx_data, rx_data, byte_v, last_tx, ctrl1, ctrl2;
	logic tx_empty, tx_taken, tx_done, rx_valid, noise, ferr, perr, idle;
	logic rx_rate, rx_bit, tx_rate, tx_bit, irq, take_en, send;
	logic [3:0] ticks;
	int failures = 0;
	int checked = 0;
	int pf[4] = '{1, 3, 4, 13};

	assign ticks = {tx_bit, rx_bit, tx_rate, rx_rate};

	asbd_serial_regs dut (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_tx_data(tx_data), .o_tx_empty(tx_empty),
		.i_tx_taken(tx_taken), .i_tx_done(tx_done), .i_rx_valid(rx_valid),
		.i_rx_data(rx_data), .i_rx_noise(noise), .i_rx_frame_err(ferr),
		.i_rx_parity_err(perr), .i_rx_idle(idle), .o_rx_rate_tick(rx_rate),
		.o_rx_bit_tick(rx_bit), .o_tx_rate_tick(tx_rate), .o_tx_bit_tick(tx_bit),
		.o_ctrl_one(ctrl1), .o_ctrl_two(ctrl2), .o_irq(irq));

	asbd_engine_model model (.i_clk(clk), .i_rst(rst), .i_take_en(take_en), .i_send(send),
		.i_byte(byte_v), .o_last_tx(last_tx), .i_tx_data(tx_data), .i_tx_empty(tx_empty),
		.o_tx_taken(tx_taken), .o_tx_done(tx_done), .o_rx_valid(rx_valid),
		.o_rx_data(rx_data), .o_rx_noise(noise), .o_rx_frame_err(ferr),
		.o_rx_parity_err(perr), .o_rx_idle(idle));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		xfer({idx, 2'b00}, 1'b1, {24'h0, d}, r, e);
		check({31'h0, e}, 32'h0);
	endtask : wr

	task automatic rd(input logic [9:0] idx, output logic [31:0] r);
		logic e;
		xfer({idx, 2'b00}, 1'b0, 32'h0, r, e);
		check({31'h0, e}, 32'h0);
	endtask : rd

	task automatic send_byte(input logic [7:0] b);
		@(posedge clk);
		send <= 1'b1;
		byte_v <= b;
		@(posedge clk);
		send <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : send_byte

	// Interval between the second and third tick, so a stale count is skipped
	task automatic measure(input int which, output int n);
		for (int j = 0; j < 3; j++)
		begin
			n = 0;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (ticks[which] !== 1'b1 && n < 9000);
		end
	endtask : measure

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] r;
		logic e;
		rd(asbd_pkg::IDX_STATUS, r);
		check(r, 32'h000000C0);
		rd(asbd_pkg::IDX_BRR, r);
		check(r, 32'h0);
		rd(asbd_pkg::IDX_RX_EXT, r);
		check(r, 32'h0);
		rd(asbd_pkg::IDX_TX_EXT, r);
		check(r, 32'h0);
		xfer(12'h158, 1'b0, 32'h0, r, e);
		check({31'h0, e}, 32'h1);
	endtask : t_reset

	task automatic t_data;
		logic [31:0] r;
		int k;
		wr(asbd_pkg::IDX_DATA, 8'hA5);
		repeat (2) @(posedge clk);
		check({24'h0, tx_data}, 32'hA5);
		check({31'h0, tx_empty}, 32'h0);
		take_en <= 1'b1;
		k = 0;
		while (tx_empty !== 1'b1 && k < 20)
		begin
			@(posedge clk);
			k++;
		end
		check({31'h0, tx_empty}, 32'h1);
		check({24'h0, last_tx}, 32'hA5);
		take_en <= 1'b0;
		send_byte(8'h3C);
		rd(asbd_pkg::IDX_STATUS, r);
		check({31'h0, r[asbd_pkg::ST_RX_READY_FLAG]}, 32'h1);
		rd(asbd_pkg::IDX_DATA, r);
		check(r, 32'h3C);
	endtask : t_data

	task automatic t_clear;
		logic [31:0] r;
		send_byte(8'h5A);
		rd(asbd_pkg::IDX_DATA, r);
		check(r, 32'h5A);
		rd(asbd_pkg::IDX_STATUS, r);
		check({31'h0, r[asbd_pkg::ST_RX_READY_FLAG]}, 32'h1);
		rd(asbd_pkg::IDX_DATA, r);
		send_byte(8'h11);
		send_byte(8'h22);
		rd(asbd_pkg::IDX_STATUS, r);
		check({31'h0, r[asbd_pkg::ST_OVR]}, 32'h1);
		rd(asbd_pkg::IDX_DATA, r);
		check(r, 32'h11);
		rd(asbd_pkg::IDX_STATUS, r);
		check({26'h0, r[5:0]}, 32'h0);
	endtask : t_clear

	task automatic t_rates;
		int n;
		for (int p = 0; p < 4; p++)
		begin
			for (int c = 0; c < 8; c++)
			begin
				wr(asbd_pkg::IDX_BRR, {p[1:0], c[2:0], 3'(7 - c)});
				measure(1, n);
				check(n, pf[p] * (1 << c));
				measure(0, n);
				check(n, pf[p] * (1 << (7 - c)));
			end
		end
	endtask : t_rates

	task automatic t_ext;
		logic [31:0] r;
		int n;
		wr(asbd_pkg::IDX_BRR, 8'h48);
		measure(3, n);
		check(n, 96);
		measure(2, n);
		check(n, 48);
		wr(asbd_pkg::IDX_RX_EXT, 8'h03);
		measure(2, n);
		check(n, 144);
		measure(3, n);
		check(n, 96);
		rd(asbd_pkg::IDX_RX_EXT, r);
		check(r, 32'h03);
		wr(asbd_pkg::IDX_RX_EXT, 8'h00);
		wr(asbd_pkg::IDX_BRR, 8'h00);
		wr(asbd_pkg::IDX_TX_EXT, 8'hFF);
		measure(3, n);
		check(n, 4080);
		measure(2, n);
		check(n, 16);
		rd(asbd_pkg::IDX_TX_EXT, r);
		check(r, 32'hFF);
		wr(asbd_pkg::IDX_TX_EXT, 8'h00);
	endtask : t_ext

	// Control copies, read-only top bit, and the low power hold of all ticks
	task automatic t_ctrl;
		logic [31:0] r;
		int k;
		wr(asbd_pkg::IDX_CR1, 8'hFF);
		wr(asbd_pkg::IDX_CR2, 8'h5A);
		rd(asbd_pkg::IDX_CR1, r);
		check(r, 32'h7F);
		check({16'h0, ctrl1, ctrl2}, 32'h00007F5A);
		k = 0;
		repeat (40)
		begin
			@(posedge clk);
			if (ticks !== 4'h0)
				k++;
		end
		check(k, 0);
		wr(asbd_pkg::IDX_CR1, 8'h00);
		wr(asbd_pkg::IDX_CR2, 8'h00);
	endtask : t_ctrl

	task automatic t_irq;
		logic [31:0] r;
		rd(asbd_pkg::IDX_DATA, r);
		wr(asbd_pkg::IDX_IRQ_STAT, 8'h0F);
		wr(asbd_pkg::IDX_IRQ_MASK, 8'h01);
		send_byte(8'h77);
		check({31'h0, irq}, 32'h1);
		wr(asbd_pkg::IDX_IRQ_STAT, 8'h01);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		wr(asbd_pkg::IDX_IRQ_MASK, 8'h00);
		rd(asbd_pkg::IDX_STATUS, r);
		rd(asbd_pkg::IDX_DATA, r);
		send_byte(8'h78);
		check({31'h0, irq}, 32'h0);
		rd(asbd_pkg::IDX_IRQ_STAT, r);
		check({31'h0, r[asbd_pkg::IRQ_RX]}, 32'h1);
	endtask : t_irq

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic wrap_up;
		if (failures == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial
	begin
		repeat (90000) @(posedge clk);
		failures++;
		wrap_up();
	end

	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		take_en = 1'b0;
		send = 1'b0;
		byte_v = 8'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_data();
		t_clear();
		t_rates();
		t_ext();
		t_ctrl();
		t_irq();
		wrap_up();
	end
endmodule : async_serial_baud_and_data_regs_tb

`default_nettype wire
